// >>> core/flow_meter_monitor.sv
// flow meter monitor: flow reporting, trip point exceptions, timed sensor zero and gas accumulators.
// assumes flow_in is already corrected and calibrated upstream and host requests are synchronous to clk.
`timescale 1ns/1ps

// Overview of operation
// - report corrected flow as read-only value
// - writable units setting, defaults to percent
// - alarm when flow above high trip
// - alarm when flow below low trip
// - warning when flow above high trip
// - warning when flow below low trip
// - clear only after recovering by hysteresis band
// - raise exception only after settling milliseconds
// - zero trigger starts zero unless inhibited
// - zero operation lasts configured milliseconds
// - recommend rezero after interval; zero disables
// - controller waits settle seconds at zero setpoint
// - total accumulator sums all flowed gas
// - writable accumulator units setting
// - user accumulator sums since last reset
// - user command starts, stops, resets accumulator
// - writable active calibration selection
module flow_meter_monitor #(
	parameter int MS_CYCLES = flow_meter_pkg::MS_CYCLES_DEFAULT
) (
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire flow_meter_pkg::param_req_s param_req,
	output flow_meter_pkg::param_rsp_s      param_rsp,
	input  wire logic [31:0]                flow_in,
	input  wire logic                       flow_valid,
	input  wire logic                       zero_inhibit,
	input  wire logic                       is_controller,
	input  wire logic                       setpoint_zero,
	output logic [3:0]                      exceptions,
	output logic                            zero_busy,
	output logic                            zero_recommended,
	output flow_meter_pkg::config_s         config_out
);
	import flow_meter_pkg::*;

	state_s s_q;
	state_s s_d;

	logic              ms_tick;
	logic              s_tick;
	logic              wr_ok;
	logic              zero_start;
	logic              zero_end;
	logic              rezero_eval_ok;
	logic [3:0]        beyond;
	logic [3:0]        recovered;
	logic [32:0]       flow_x;
	logic [3:0][32:0]  trip_x;
	logic [1:0][32:0]  band_x;

	assign ms_tick    = s_q.ms_cnt == 32'(MS_CYCLES - 1);
	assign s_tick     = ms_tick && s_q.ms_in_s == MS_PER_S - 10'd1;
	assign wr_ok      = param_req.wr;
	assign zero_start = wr_ok && param_req.id == ID_ZERO_TRIGGER && param_req.wdata[0]
		&& !zero_inhibit && !s_q.zero_busy;
	assign zero_end   = s_q.zero_busy && s_q.zero_ms >= s_q.zero_duration;
	assign rezero_eval_ok = !is_controller
		|| (setpoint_zero && s_q.setpoint_zero_s >= s_q.rezero_settle);

	// trip comparisons on sign-extended values so the band arithmetic cannot wrap
	always_comb begin
		flow_x    = {s_q.flow[31], s_q.flow};
		beyond    = '0;
		recovered = '0;
		for (int c = 0; c < 4; c++) begin
			trip_x[c] = {s_q.trip[c][31], s_q.trip[c]};
		end
		for (int b = 0; b < 2; b++) begin
			band_x[b] = {s_q.band[b][31], s_q.band[b]};
		end
		for (int c = 0; c < 4; c++) begin
			if (c % 2 == 0) begin
				beyond[c]    = $signed(flow_x) > $signed(trip_x[c]);
				recovered[c] = $signed(flow_x) <= $signed(trip_x[c]) - $signed(band_x[c / 2]);
			end else begin
				beyond[c]    = $signed(flow_x) < $signed(trip_x[c]);
				recovered[c] = $signed(flow_x) >= $signed(trip_x[c]) + $signed(band_x[c / 2]);
			end
		end
	end

	always_comb begin
		s_d = s_q;

		// time base
		s_d.ms_cnt = ms_tick ? 32'h0 : s_q.ms_cnt + 32'h1;
		if (ms_tick) begin
			s_d.ms_in_s = s_tick ? 10'h0 : s_q.ms_in_s + 10'h1;
		end

		if (flow_valid) begin
			s_d.flow = flow_in;
		end

		// exception channels
		for (int c = 0; c < 4; c++) begin
			if (s_q.cond[c]) begin
				s_d.settle[c] = '0;
				if (recovered[c]) begin
					s_d.cond[c] = 1'b0;
				end
			end else if (!beyond[c]) begin
				s_d.settle[c] = '0;
			end else if (s_q.settle[c] >= s_q.delay[c / 2]) begin
				s_d.cond[c]   = 1'b1;
				s_d.settle[c] = '0;
			end else if (ms_tick) begin
				s_d.settle[c] = s_q.settle[c] + 32'h1;
			end
		end

		// accumulators advance by one flow sample per millisecond
		if (ms_tick) begin
			s_d.total_acc = s_q.total_acc + s_q.flow;
			if (s_q.user_run) begin
				s_d.user_acc = s_q.user_acc + s_q.flow;
			end
		end

		// flowing hours: seconds with non-zero flow, rolled into hours
		if (s_tick && s_q.flow != 32'h0) begin
			if (s_q.flow_s_in_h == S_PER_H - 12'd1) begin
				s_d.flow_s_in_h   = 12'h0;
				s_d.flowing_hours = s_q.flowing_hours + 32'h1;
			end else begin
				s_d.flow_s_in_h = s_q.flow_s_in_h + 12'h1;
			end
		end

		// sensor zero
		if (zero_start) begin
			s_d.zero_busy = 1'b1;
			s_d.zero_ms   = 32'h0;
		end else if (zero_end) begin
			s_d.zero_busy = 1'b0;
		end else if (s_q.zero_busy && ms_tick) begin
			s_d.zero_ms = s_q.zero_ms + 32'h1;
		end

		// rezero recommendation
		if (s_tick && s_q.since_zero_s != 32'hffff_ffff) begin
			s_d.since_zero_s = s_q.since_zero_s + 32'h1;
		end
		if (!setpoint_zero) begin
			s_d.setpoint_zero_s = 32'h0;
		end else if (s_tick && s_q.setpoint_zero_s != 32'hffff_ffff) begin
			s_d.setpoint_zero_s = s_q.setpoint_zero_s + 32'h1;
		end
		if (zero_end) begin
			s_d.since_zero_s = 32'h0;
		end
		if (s_q.rezero_interval == 32'h0 || zero_end) begin
			s_d.zero_recommended = 1'b0;
		end else if (rezero_eval_ok && s_q.since_zero_s >= s_q.rezero_interval) begin
			s_d.zero_recommended = 1'b1;
		end

		// host writes; a write to an accumulator overrides the same-cycle sum
		if (wr_ok) begin
			case (param_req.id)
				ID_UNITS_SELECT:    s_d.cfg.units = param_req.wdata;
				ID_ALARM_HIGH:      s_d.trip[CH_ALARM_HIGH] = param_req.wdata;
				ID_ALARM_LOW:       s_d.trip[CH_ALARM_LOW] = param_req.wdata;
				ID_ALARM_BAND:      s_d.band[0] = param_req.wdata;
				ID_ALARM_DELAY:     s_d.delay[0] = param_req.wdata;
				ID_WARNING_HIGH:    s_d.trip[CH_WARNING_HIGH] = param_req.wdata;
				ID_WARNING_LOW:     s_d.trip[CH_WARNING_LOW] = param_req.wdata;
				ID_WARNING_BAND:    s_d.band[1] = param_req.wdata;
				ID_WARNING_DELAY:   s_d.delay[1] = param_req.wdata;
				ID_CAL_SELECT:      s_d.cfg.cal_select = param_req.wdata;
				ID_ZERO_DURATION:   s_d.zero_duration = param_req.wdata;
				ID_ACC_UNITS:       s_d.cfg.acc_units = param_req.wdata;
				ID_TOTAL_ACC:       s_d.total_acc = param_req.wdata;
				ID_USER_ACC:        s_d.user_acc = param_req.wdata;
				ID_REZERO_INTERVAL: s_d.rezero_interval = param_req.wdata;
				ID_REZERO_SETTLE:   s_d.rezero_settle = param_req.wdata;
				ID_USER_CMD: begin
					s_d.user_cmd = param_req.wdata;
					case (param_req.wdata)
						USER_CMD_START: s_d.user_run = 1'b1;
						USER_CMD_STOP:  s_d.user_run = 1'b0;
						USER_CMD_RESET: s_d.user_acc = 32'h0;
						default:        s_d.user_run = s_q.user_run;
					endcase
				end
				default: s_d.user_cmd = s_q.user_cmd;
			endcase
		end

		// host answer, one cycle after the request
		s_d.rsp.ack   = param_req.wr || param_req.rd;
		s_d.rsp.err   = 1'b0;
		s_d.rsp.rdata = 32'h0;
		case (param_req.id)
			ID_UNITS_SELECT:    s_d.rsp.rdata = s_q.cfg.units;
			ID_MEASURED_FLOW:   s_d.rsp.rdata = s_q.flow;
			ID_ALARM_HIGH:      s_d.rsp.rdata = s_q.trip[CH_ALARM_HIGH];
			ID_ALARM_LOW:       s_d.rsp.rdata = s_q.trip[CH_ALARM_LOW];
			ID_ALARM_BAND:      s_d.rsp.rdata = s_q.band[0];
			ID_ALARM_DELAY:     s_d.rsp.rdata = s_q.delay[0];
			ID_WARNING_HIGH:    s_d.rsp.rdata = s_q.trip[CH_WARNING_HIGH];
			ID_WARNING_LOW:     s_d.rsp.rdata = s_q.trip[CH_WARNING_LOW];
			ID_WARNING_BAND:    s_d.rsp.rdata = s_q.band[1];
			ID_WARNING_DELAY:   s_d.rsp.rdata = s_q.delay[1];
			ID_CAL_SELECT:      s_d.rsp.rdata = s_q.cfg.cal_select;
			ID_FLOWING_HOURS:   s_d.rsp.rdata = s_q.flowing_hours;
			ID_ZERO_DURATION:   s_d.rsp.rdata = s_q.zero_duration;
			ID_ZERO_TRIGGER:    s_d.rsp.rdata = {31'h0, s_q.zero_busy};
			ID_ACC_UNITS:       s_d.rsp.rdata = s_q.cfg.acc_units;
			ID_TOTAL_ACC:       s_d.rsp.rdata = s_q.total_acc;
			ID_USER_ACC:        s_d.rsp.rdata = s_q.user_acc;
			ID_USER_CMD:        s_d.rsp.rdata = s_q.user_cmd;
			ID_REZERO_INTERVAL: s_d.rsp.rdata = s_q.rezero_interval;
			ID_REZERO_SETTLE:   s_d.rsp.rdata = s_q.rezero_settle;
			default:            s_d.rsp.err = s_d.rsp.ack;
		endcase
		// read-only ids refuse writes
		if (param_req.wr && (param_req.id == ID_MEASURED_FLOW || param_req.id == ID_FLOWING_HOURS)) begin
			s_d.rsp.err = 1'b1;
		end
		if (!s_d.rsp.ack) begin
			s_d.rsp.rdata = 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= STATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign param_rsp        = s_q.rsp;
	assign exceptions       = s_q.cond;
	assign zero_busy        = s_q.zero_busy;
	assign zero_recommended = s_q.zero_recommended;
	assign config_out       = s_q.cfg;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence zero_request;
		param_req.wr && param_req.id == ID_ZERO_TRIGGER && param_req.wdata[0] && !s_q.zero_busy;
	endsequence

	sequence zero_allowed;
		zero_request and !zero_inhibit;
	endsequence

	a_units_default: assert property ($past(reset) |-> s_q.cfg.units == UNITS_PERCENT)
		else $error("units not percent after reset");

	a_flow_capture: assert property (flow_valid |=> s_q.flow == $past(flow_in))
		else $error("flow sample not captured");

	a_flow_readonly: assert property (param_req.wr && param_req.id == ID_MEASURED_FLOW && !flow_valid
		|=> param_rsp.err && s_q.flow == $past(s_q.flow))
		else $error("measured flow changed by host write");

	a_alarm_high_set: assert property ($rose(exceptions[CH_ALARM_HIGH])
		|-> $past(beyond[CH_ALARM_HIGH] && s_q.settle[CH_ALARM_HIGH] >= s_q.delay[0]))
		else $error("high alarm raised without sustained excursion");

	a_alarm_low_set: assert property ($rose(exceptions[CH_ALARM_LOW])
		|-> $past(beyond[CH_ALARM_LOW] && s_q.settle[CH_ALARM_LOW] >= s_q.delay[0]))
		else $error("low alarm raised without sustained excursion");

	a_warn_high_set: assert property ($rose(exceptions[CH_WARNING_HIGH])
		|-> $past(beyond[CH_WARNING_HIGH] && s_q.settle[CH_WARNING_HIGH] >= s_q.delay[1]))
		else $error("high warning raised without sustained excursion");

	a_warn_low_set: assert property ($rose(exceptions[CH_WARNING_LOW])
		|-> $past(beyond[CH_WARNING_LOW] && s_q.settle[CH_WARNING_LOW] >= s_q.delay[1]))
		else $error("low warning raised without sustained excursion");

	a_band_clear: assert property ($fell(exceptions[CH_ALARM_HIGH]) |-> $past(recovered[CH_ALARM_HIGH]))
		else $error("high alarm cleared inside hysteresis band");

	a_settle_restart: assert property (!s_q.cond[CH_WARNING_LOW] && !beyond[CH_WARNING_LOW]
		|=> s_q.settle[CH_WARNING_LOW] == 32'h0 && !$rose(exceptions[CH_WARNING_LOW]))
		else $error("settling timer kept running after excursion ended");

	a_zero_start: assert property (zero_allowed |=> zero_busy && s_q.zero_ms == 32'h0)
		else $error("zero did not start");

	a_zero_inhibit: assert property (zero_request and zero_inhibit |=> !zero_busy)
		else $error("zero started while inhibited");

	a_zero_length: assert property ($fell(zero_busy) |-> $past(s_q.zero_ms >= s_q.zero_duration))
		else $error("zero ended before its duration");

	a_rezero_off: assert property (s_q.rezero_interval == 32'h0 |=> !zero_recommended)
		else $error("rezero recommended while disabled");

	a_rezero_wait: assert property ($rose(zero_recommended) && $past(is_controller)
		|-> $past(setpoint_zero && s_q.setpoint_zero_s >= s_q.rezero_settle))
		else $error("rezero evaluated before setpoint settle time");

	a_user_reset: assert property (param_req.wr && param_req.id == ID_USER_CMD
		&& param_req.wdata == USER_CMD_RESET |=> s_q.user_acc == 32'h0)
		else $error("user accumulator not cleared");

	a_user_stopped: assert property (!s_q.user_run && !(param_req.wr && param_req.id == ID_USER_ACC)
		&& !(param_req.wr && param_req.id == ID_USER_CMD && param_req.wdata == USER_CMD_RESET)
		|=> s_q.user_acc == $past(s_q.user_acc))
		else $error("stopped user accumulator moved");

	a_cal_select: assert property (param_req.wr && param_req.id == ID_CAL_SELECT
		|=> config_out.cal_select == $past(param_req.wdata) && param_rsp.ack && !param_rsp.err)
		else $error("calibration select not stored");

	a_total_sums: assert property (ms_tick && !(param_req.wr && param_req.id == ID_TOTAL_ACC)
		|=> s_q.total_acc == $past(s_q.total_acc) + $past(s_q.flow))
		else $error("total accumulator did not add flow");

	a_alarm_hold: assert property (s_q.cond[CH_ALARM_HIGH] && !recovered[CH_ALARM_HIGH]
		|=> exceptions[CH_ALARM_HIGH])
		else $error("high alarm dropped inside hysteresis band");

	a_band_low: assert property ($fell(exceptions[CH_ALARM_LOW]) |-> $past(recovered[CH_ALARM_LOW]))
		else $error("low alarm cleared inside hysteresis band");

	a_warn_band: assert property ($fell(exceptions[CH_WARNING_HIGH])
		|-> $past(recovered[CH_WARNING_HIGH]))
		else $error("high warning cleared inside hysteresis band");

	a_alarm_fire: assert property (!s_q.cond[CH_ALARM_HIGH] && beyond[CH_ALARM_HIGH]
		&& s_q.settle[CH_ALARM_HIGH] >= s_q.delay[0] |=> exceptions[CH_ALARM_HIGH])
		else $error("high alarm not raised after settling time");

	a_warn_fire: assert property (!s_q.cond[CH_WARNING_LOW] && beyond[CH_WARNING_LOW]
		&& s_q.settle[CH_WARNING_LOW] >= s_q.delay[1] |=> exceptions[CH_WARNING_LOW])
		else $error("low warning not raised after settling time");

	a_settle_step: assert property (!s_q.cond[CH_ALARM_HIGH] && beyond[CH_ALARM_HIGH] && ms_tick
		&& s_q.settle[CH_ALARM_HIGH] < s_q.delay[0]
		|=> s_q.settle[CH_ALARM_HIGH] == $past(s_q.settle[CH_ALARM_HIGH]) + 32'h1)
		else $error("settling timer did not count");

	a_no_early_set: assert property (!s_q.cond[CH_ALARM_LOW]
		&& s_q.settle[CH_ALARM_LOW] < s_q.delay[0] |=> !exceptions[CH_ALARM_LOW])
		else $error("low alarm raised before settling time");

	a_zero_hold: assert property (zero_busy && s_q.zero_ms < s_q.zero_duration |=> zero_busy)
		else $error("zero ended early");

	a_zero_count: assert property (zero_busy && !zero_end && ms_tick
		|=> s_q.zero_ms == $past(s_q.zero_ms) + 32'h1)
		else $error("zero timer did not count");

	a_rezero_set: assert property (!is_controller && s_q.rezero_interval != 32'h0 && !zero_end
		&& s_q.since_zero_s >= s_q.rezero_interval |=> zero_recommended)
		else $error("rezero not recommended after interval");

	a_rezero_gate: assert property (is_controller && !setpoint_zero && !zero_recommended
		|=> !zero_recommended)
		else $error("rezero evaluated with setpoint not zero");

	a_units_write: assert property (param_req.wr && param_req.id == ID_UNITS_SELECT
		|=> config_out.units == $past(param_req.wdata))
		else $error("units select not stored");

	a_acc_units: assert property (param_req.wr && param_req.id == ID_ACC_UNITS
		|=> config_out.acc_units == $past(param_req.wdata))
		else $error("accumulator units not stored");

	a_user_sums: assert property (ms_tick && s_q.user_run
		&& !(param_req.wr && (param_req.id == ID_USER_ACC || param_req.id == ID_USER_CMD))
		|=> s_q.user_acc == $past(s_q.user_acc) + $past(s_q.flow))
		else $error("running user accumulator did not add flow");

	a_flow_read: assert property (param_req.rd && param_req.id == ID_MEASURED_FLOW
		|=> param_rsp.ack && param_rsp.rdata == $past(s_q.flow))
		else $error("flow read returned wrong value");

endmodule // flow_meter_monitor

// >>> core/flow_meter_pkg.sv
// package for the flow meter monitor: parameter ids, reset values, timing counts and carrier structs.
// assumes a single 50 MHz clock and flow values as signed 32-bit fixed-point numbers.
package flow_meter_pkg;

	// parameter ids as seen by the fieldbus host
	localparam logic [7:0] ID_UNITS_SELECT    = 8'h04;
	localparam logic [7:0] ID_MEASURED_FLOW   = 8'h06;
	localparam logic [7:0] ID_ALARM_HIGH      = 8'h11;
	localparam logic [7:0] ID_ALARM_LOW       = 8'h12;
	localparam logic [7:0] ID_ALARM_BAND      = 8'h13;
	localparam logic [7:0] ID_ALARM_DELAY     = 8'h14;
	localparam logic [7:0] ID_WARNING_HIGH    = 8'h15;
	localparam logic [7:0] ID_WARNING_LOW     = 8'h16;
	localparam logic [7:0] ID_WARNING_BAND    = 8'h17;
	localparam logic [7:0] ID_WARNING_DELAY   = 8'h18;
	localparam logic [7:0] ID_CAL_SELECT      = 8'h23;
	localparam logic [7:0] ID_FLOWING_HOURS   = 8'h60;
	localparam logic [7:0] ID_ZERO_DURATION   = 8'h69;
	localparam logic [7:0] ID_ZERO_TRIGGER    = 8'h70;
	localparam logic [7:0] ID_ACC_UNITS       = 8'h7d;
	localparam logic [7:0] ID_TOTAL_ACC       = 8'h7e;
	localparam logic [7:0] ID_USER_ACC        = 8'h82;
	localparam logic [7:0] ID_USER_CMD        = 8'h83;
	localparam logic [7:0] ID_REZERO_INTERVAL = 8'h8c;
	localparam logic [7:0] ID_REZERO_SETTLE   = 8'h8d;

	// reset values; unit codes are arbitrary encodings
	localparam logic [31:0] UNITS_PERCENT     = 32'h0000_0001;
	localparam logic [31:0] ACC_UNITS_DEFAULT = 32'h0000_0001;

	// user accumulator commands
	localparam logic [31:0] USER_CMD_START = 32'h0000_0001;
	localparam logic [31:0] USER_CMD_STOP  = 32'h0000_0002;
	localparam logic [31:0] USER_CMD_RESET = 32'h0000_0003;

	// timing
	localparam int CLK_PERIOD_NS     = 20;
	localparam int TICK_PERIOD_MS    = 1;
	localparam int MS_CYCLES_DEFAULT = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [9:0]  MS_PER_S = 10'd1000;
	localparam logic [11:0] S_PER_H  = 12'd3600;

	// exception channel order
	localparam int CH_ALARM_HIGH   = 0;
	localparam int CH_ALARM_LOW    = 1;
	localparam int CH_WARNING_HIGH = 2;
	localparam int CH_WARNING_LOW  = 3;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  id;
		logic [31:0] wdata;
	} param_req_s;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} param_rsp_s;

	typedef struct packed {
		logic [31:0] units;
		logic [31:0] acc_units;
		logic [31:0] cal_select;
	} config_s;

	typedef struct packed {
		config_s          cfg;
		logic [31:0]      flow;
		logic [3:0][31:0] trip;
		logic [1:0][31:0] band;
		logic [1:0][31:0] delay;
		logic [31:0]      flowing_hours;
		logic [31:0]      zero_duration;
		logic [31:0]      total_acc;
		logic [31:0]      user_acc;
		logic [31:0]      user_cmd;
		logic             user_run;
		logic [31:0]      rezero_interval;
		logic [31:0]      rezero_settle;
		logic             zero_busy;
		logic [31:0]      zero_ms;
		logic [31:0]      since_zero_s;
		logic [31:0]      setpoint_zero_s;
		logic             zero_recommended;
		logic [3:0]       cond;
		logic [3:0][31:0] settle;
		logic [31:0]      ms_cnt;
		logic [9:0]       ms_in_s;
		logic [11:0]      flow_s_in_h;
		param_rsp_s       rsp;
	} state_s;

	localparam state_s STATE_RESET = '{cfg: '{units: UNITS_PERCENT, acc_units: ACC_UNITS_DEFAULT, cal_select: 32'h0},
		default: '0};

endpackage : flow_meter_pkg

// >>> dv/flow_host_model.sv
// fieldbus host model: issues one parameter request at a time on the parameter port.
// assumes the monitor registers its answer on the same edge that takes the request.
`timescale 1ns/1ps
module flow_host_model (
	input  wire logic                       clk,
	output flow_meter_pkg::param_req_s      param_req,
	input  wire flow_meter_pkg::param_rsp_s param_rsp
);
	import flow_meter_pkg::*;

	initial begin
		param_req = '0;
	end

	// strobe is a one-cycle pulse; the answer stands one cycle, so it is sampled at the next falling edge
	task automatic access(input logic wr, input logic [7:0] id, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err, output logic ack);
		@(negedge clk);
		param_req.wr    = wr;
		param_req.rd    = !wr;
		param_req.id    = id;
		param_req.wdata = wdata;
		@(negedge clk);
		ack             = param_rsp.ack;
		err             = param_rsp.err;
		rdata           = param_rsp.rdata;
		param_req.wr    = 1'b0;
		param_req.rd    = 1'b0;
		// released lines carry no meaning; scramble them so nothing leans on stale values
		param_req.id    = ~id;
		param_req.wdata = ~wdata;
	endtask
endmodule // flow_host_model

// >>> dv/flow_meter_monitor_tb.sv
// testbench for the flow meter monitor: host model drives parameters, bench drives flow and status inputs.
// assumes a 4-cycle millisecond tick so that timed behaviour fits a short run.
`timescale 1ns/1ps
module flow_meter_monitor_tb;
	import flow_meter_pkg::*;

	localparam int MS = 4;
	localparam int LIMIT = 40000;

	logic        clk;
	logic        reset;
	param_req_s  param_req;
	param_rsp_s  param_rsp;
	logic [31:0] flow_in;
	logic        flow_valid;
	logic        zero_inhibit;
	logic        is_controller;
	logic        setpoint_zero;
	logic [3:0]  exceptions;
	logic        zero_busy;
	logic        zero_recommended;
	config_s     config_out;
	int          miscompares = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          n;
	logic [31:0] d;
	logic [31:0] d2;
	logic        e;
	logic        a;
	logic [31:0] fv [5] = '{32'd0, 32'd700, 32'd1200, -32'sd700, -32'sd1200};
	logic [3:0]  em [5] = '{4'h0, 4'h4, 4'h5, 4'h8, 4'ha};

	flow_meter_monitor #(.MS_CYCLES(MS)) u_dut (
		.clk(clk), .reset(reset), .param_req(param_req), .param_rsp(param_rsp),
		.flow_in(flow_in), .flow_valid(flow_valid), .zero_inhibit(zero_inhibit),
		.is_controller(is_controller), .setpoint_zero(setpoint_zero), .exceptions(exceptions),
		.zero_busy(zero_busy), .zero_recommended(zero_recommended), .config_out(config_out)
	);

	flow_host_model u_host (.clk(clk), .param_req(param_req), .param_rsp(param_rsp));

	always #10 clk = ~clk;

	task automatic final_report();
		if (miscompares == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			final_report();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic check_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi,
		input string what);
		tests_run++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h outside %h..%h", $time, what, got, lo, hi);
		end
	endtask

	task automatic wr(input logic [7:0] id, input logic [31:0] wd);
		u_host.access(1'b1, id, wd, d, e, a);
		check({30'h0, a, e}, 32'h2, "write answer");
	endtask

	task automatic rd(input logic [7:0] id);
		u_host.access(1'b0, id, 32'h0, d, e, a);
		check({30'h0, a, e}, 32'h2, "read answer");
	endtask

	task automatic set_flow(input logic [31:0] v, input int wait_cycles);
		@(negedge clk);
		flow_in = v;
		repeat (wait_cycles) @(negedge clk);
	endtask

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		flow_in = '0;
		flow_valid = 1'b1;
		zero_inhibit = 1'b1;
		is_controller = 1'b0;
		setpoint_zero = 1'b0;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		check(config_out.units, UNITS_PERCENT, "units after reset");
		rd(ID_UNITS_SELECT);
		check(d, UNITS_PERCENT, "units read");
		wr(ID_UNITS_SELECT, 32'h5);
		wr(ID_ACC_UNITS, 32'h7);
		wr(ID_CAL_SELECT, 32'h2);
		check({config_out.units, config_out.acc_units}, {32'h5, 32'h7}, "units out");
		check(config_out.cal_select, 32'h2, "calibration out");
		rd(ID_ACC_UNITS);
		check(d, 32'h7, "accumulator units read");
		rd(ID_CAL_SELECT);
		check(d, 32'h2, "calibration read");
		set_flow(32'h123, 2);
		rd(ID_MEASURED_FLOW);
		check(d, 32'h123, "flow read");
		// no valid strobe: a new sample on flow_in must not be taken
		flow_valid = 1'b0;
		flow_in = 32'h77;
		u_host.access(1'b1, ID_MEASURED_FLOW, 32'h55, d, e, a);
		check({30'h0, a, e}, 32'h3, "flow write refused");
		rd(ID_MEASURED_FLOW);
		check(d, 32'h123, "flow unchanged");
		flow_valid = 1'b1;
		u_host.access(1'b0, 8'hee, 32'h0, d, e, a);
		check({d[29:0], a, e}, 32'h3, "unknown id");
		wr(ID_ALARM_HIGH, 32'd1000);
		wr(ID_ALARM_LOW, -32'sd1000);
		wr(ID_WARNING_HIGH, 32'd500);
		wr(ID_WARNING_LOW, -32'sd500);
		for (int i = 0; i < 5; i++) begin
			set_flow(fv[i], 4);
			check({28'h0, exceptions}, {28'h0, em[i]}, "exception mask");
		end
		set_flow(32'd0, 4);
		wr(ID_ALARM_BAND, 32'd100);
		wr(ID_ALARM_DELAY, 32'd4);
		// two short excursions, of three ticks and then two ticks, must not add up
		set_flow(32'd1200, 8);
		set_flow(32'd0, 4);
		set_flow(32'd1200, 8);
		check({31'h0, exceptions[0]}, 32'h0, "short excursions");
		set_flow(32'd0, 4);
		set_flow(32'd1200, 8);
		check({31'h0, exceptions[0]}, 32'h0, "before settling");
		repeat (16) @(negedge clk);
		check({31'h0, exceptions[0]}, 32'h1, "after settling");
		set_flow(32'd950, 4);
		check({31'h0, exceptions[0]}, 32'h1, "inside recovery band");
		set_flow(32'd900, 4);
		check({31'h0, exceptions[0]}, 32'h0, "recovered past band");
		wr(ID_ZERO_DURATION, 32'd5);
		wr(ID_ZERO_TRIGGER, 32'h1);
		check({31'h0, zero_busy}, 32'h0, "zero inhibited");
		zero_inhibit = 1'b0;
		wr(ID_ZERO_TRIGGER, 32'h1);
		check({31'h0, zero_busy}, 32'h1, "zero started");
		n = 0;
		while (zero_busy === 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		check_range(n, 4 * MS, 6 * MS + 2, "zero duration");
		wr(ID_REZERO_INTERVAL, 32'd2);
		repeat (3900) @(negedge clk);
		check({31'h0, zero_recommended}, 32'h0, "rezero too early");
		n = 0;
		while (zero_recommended !== 1'b1 && n < 4400) begin
			@(negedge clk);
			n++;
		end
		check({31'h0, zero_recommended}, 32'h1, "rezero recommended");
		wr(ID_REZERO_INTERVAL, 32'd0);
		// the flag clears one cycle after the new interval is stored
		@(negedge clk);
		check({31'h0, zero_recommended}, 32'h0, "rezero disabled");
		is_controller = 1'b1;
		wr(ID_REZERO_SETTLE, 32'd2);
		wr(ID_REZERO_INTERVAL, 32'd2);
		repeat (6000) @(negedge clk);
		check({31'h0, zero_recommended}, 32'h0, "setpoint not zero");
		setpoint_zero = 1'b1;
		// two settle seconds need at least two second ticks, over 4000 cycles
		repeat (3900) @(negedge clk);
		check({31'h0, zero_recommended}, 32'h0, "setpoint settle wait");
		n = 0;
		while (zero_recommended !== 1'b1 && n < 8400) begin
			@(negedge clk);
			n++;
		end
		check({31'h0, zero_recommended}, 32'h1, "setpoint settled");
		set_flow(32'd10, 1);
		wr(ID_TOTAL_ACC, 32'd0);
		wr(ID_USER_CMD, USER_CMD_RESET);
		wr(ID_USER_CMD, USER_CMD_START);
		repeat (40) @(negedge clk);
		wr(ID_USER_CMD, USER_CMD_STOP);
		rd(ID_USER_ACC);
		d2 = d;
		check_range(d2, 32'd90, 32'd120, "user accumulator running");
		rd(ID_TOTAL_ACC);
		check_range(d, 32'd100, 32'd160, "total accumulator");
		repeat (20) @(negedge clk);
		rd(ID_USER_ACC);
		check(d, d2, "user accumulator stopped");
		wr(ID_USER_CMD, USER_CMD_RESET);
		rd(ID_USER_ACC);
		check(d, 32'd0, "user accumulator reset");
		wr(ID_USER_CMD, USER_CMD_START);
		repeat (20) @(negedge clk);
		rd(ID_USER_ACC);
		check_range(d, 32'd40, 32'd70, "user accumulator restarted");
		final_report();
	end
endmodule // flow_meter_monitor_tb
